// ===== nca_defs.svh
// nca_defs.svh: offsets, field positions and reset values for the nibble alu
// assumes inclusion by bare name from the package and the design file
`ifndef NCA_DEFS_SVH
`define NCA_DEFS_SVH

// table word split
`define NCA_ROM_D_MSB 9
`define NCA_ROM_D_LSB 8
`define NCA_ROM_B_MSB 7
`define NCA_ROM_B_LSB 4
`define NCA_ROM_A_MSB 3
`define NCA_ROM_A_LSB 0

// widths
`define NCA_NIB_W 4
`define NCA_PAGE_W 6
`define NCA_DREG_W 3
`define NCA_ROM_W 10
`define NCA_ROM_ADDR_W 13

// largest page operand on the larger program memory
`define NCA_PAGE_MAX_DEF 63

// reset values
`define NCA_ACC_RST 4'h0
`define NCA_B_RST 4'h0
`define NCA_D_RST 3'h0
`define NCA_CARRY_RST 1'b0

`endif

// ===== nca_pkg.sv
// nca_pkg.sv: types shared by the nibble alu and its sequencer
// assumes nca_defs.svh is on the include path
`include "nca_defs.svh"

package nca_pkg;

  typedef enum logic [4:0] {
    NCA_OP_NOP  = 5'b00000,
    NCA_OP_LDI  = 5'b00001,
    NCA_OP_TBR  = 5'b00010,
    NCA_OP_ADDM = 5'b00011,
    NCA_OP_ADDC = 5'b00100,
    NCA_OP_ADDI = 5'b00101,
    NCA_OP_AND  = 5'b00110,
    NCA_OP_OR   = 5'b00111,
    NCA_OP_SETC = 5'b01000,
    NCA_OP_CLRC = 5'b01001,
    NCA_OP_TSTC = 5'b01010,
    NCA_OP_CPL  = 5'b01011,
    NCA_OP_ROR  = 5'b01100,
    NCA_OP_BSET = 5'b01101,
    NCA_OP_BCLR = 5'b01110,
    NCA_OP_BTST = 5'b01111,
    NCA_OP_CMPM = 5'b10000,
    NCA_OP_CMPI = 5'b10001
  } nca_op_t;

  typedef enum logic [0:0] {
    NCA_ST_IDLE = 1'b0,
    NCA_ST_ROM  = 1'b1
  } nca_state_t;

  typedef struct packed {
    nca_op_t op;
    logic [`NCA_NIB_W-1:0] imm;
    logic [`NCA_PAGE_W-1:0] page;
  } nca_instr_t;

endpackage

// ===== nca_alu.sv
// nca_alu.sv: accumulator, carry, table-read and memory-bit execution unit
// assumes a sequencer that offers one instruction per handshake and a data
// memory that presents the pointed nibble combinationally on mem_rdata_in
//
// Operation
// - load immediate writes operand; later loads of a back-to-back run are skipped
// - table read: word bits 9-8 to D, 7-4 to B, 3-0 to accumulator
// - table address is page, then D low three bits, then accumulator
// - table read holds one return-stack level while it runs
// - add memory sums accumulator and nibble, carry untouched
// - add with carry sums accumulator, nibble, carry; carry out kept
// - add immediate keeps carry; skips next unless sum overflows
// - and combines accumulator with pointed nibble
// - or combines accumulator with pointed nibble
// - set carry forces one, clear carry forces zero
// - carry test skips next when carry is zero
// - complement inverts the accumulator
// - rotate shifts accumulator right one place through carry
// - bit set forces indexed nibble bit to one
// - bit clear forces indexed nibble bit to zero
// - bit test skips next when indexed bit is zero
// - memory compare skips next when accumulator equals nibble
// - immediate compare skips next when accumulator equals operand
`timescale 1ns/1ns
`include "nca_defs.svh"

module nca_alu
  import nca_pkg::*;
#(
  parameter int PAGE_MAX = `NCA_PAGE_MAX_DEF
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // instruction from the sequencer
  input wire logic instr_valid_in,
  input wire nca_instr_t instr_in,
  output logic instr_ready_out,
  // pointed data memory nibble
  input wire logic [`NCA_NIB_W-1:0] mem_rdata_in,
  output logic mem_we_out,
  output logic [`NCA_NIB_W-1:0] mem_wdata_out,
  // program memory table port
  output logic rom_rd_out,
  output logic [`NCA_ROM_ADDR_W-1:0] rom_addr_out,
  input wire logic rom_valid_in,
  input wire logic [`NCA_ROM_W-1:0] rom_data_in,
  // return stack accounting
  input wire logic stack_full_in,
  output logic stack_claim_out,
  // architectural state
  output logic [`NCA_NIB_W-1:0] acc_out,
  output logic carry_flag_out,
  output logic [`NCA_NIB_W-1:0] b_reg_out,
  output logic [`NCA_DREG_W-1:0] d_reg_out,
  output logic skip_out,
  // faults
  output logic page_err_out,
  output logic stack_ovf_out
);

  // refused at elaboration: the page operand is six bits wide
  if (PAGE_MAX < 0 || PAGE_MAX > 63) begin : g_page_chk
    $error("PAGE_MAX must fit a six bit page operand");
  end

  localparam logic [`NCA_PAGE_W-1:0] PAGE_LIM = PAGE_MAX[`NCA_PAGE_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // state
  nca_state_t state_q;
  logic [`NCA_NIB_W-1:0] acc_q;
  logic [`NCA_NIB_W-1:0] b_q;
  logic [`NCA_DREG_W-1:0] d_q;
  logic carry_q;
  logic skip_q;
  logic ldi_run_q;
  logic mem_we_q;
  logic [`NCA_NIB_W-1:0] mem_wdata_q;
  logic rom_rd_q;
  logic [`NCA_ROM_ADDR_W-1:0] rom_addr_q;
  logic page_err_q;
  logic stack_ovf_q;

  ////////////////////////////////////////////////////////////////////////////
  // decode and datapath
  logic take;
  logic exec;
  logic ldi_suppr;
  nca_op_t op;
  logic [`NCA_NIB_W-1:0] imm;
  logic [`NCA_NIB_W:0] sum_m;
  logic [`NCA_NIB_W:0] sum_c;
  logic [`NCA_NIB_W:0] sum_i;
  logic [1:0] bit_idx;
  logic [`NCA_NIB_W-1:0] bit_mask;
  logic skip_cond;
  logic tbr_start;
  logic tbr_page_bad;

  assign op = instr_in.op;
  assign imm = instr_in.imm;
  assign instr_ready_out = (state_q == NCA_ST_IDLE);
  assign take = instr_valid_in && instr_ready_out;
  assign ldi_suppr = ldi_run_q && (op == NCA_OP_LDI);
  assign exec = take && !skip_q && !ldi_suppr;
  assign sum_m = {1'b0, acc_q} + {1'b0, mem_rdata_in};
  assign sum_c = {1'b0, acc_q} + {1'b0, mem_rdata_in} + {4'h0, carry_q};
  assign sum_i = {1'b0, acc_q} + {1'b0, imm};
  assign bit_idx = imm[1:0];
  assign bit_mask = 4'h1 << bit_idx;
  assign tbr_page_bad = instr_in.page > PAGE_LIM;
  assign tbr_start = exec && (op == NCA_OP_TBR) && !tbr_page_bad && !stack_full_in;

  always_comb begin
    case (op)
      NCA_OP_ADDI: skip_cond = !sum_i[`NCA_NIB_W];
      NCA_OP_TSTC: skip_cond = !carry_q;
      NCA_OP_BTST: skip_cond = !(|(mem_rdata_in & bit_mask));
      NCA_OP_CMPM: skip_cond = (acc_q == mem_rdata_in);
      NCA_OP_CMPI: skip_cond = (acc_q == imm);
      default: skip_cond = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // table read sequencing
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= NCA_ST_IDLE;
      rom_rd_q <= 1'b0;
      rom_addr_q <= '0;
    end else begin
      case (state_q)
        NCA_ST_IDLE: begin
          if (tbr_start) begin
            state_q <= NCA_ST_ROM;
            rom_rd_q <= 1'b1;
            rom_addr_q <= {instr_in.page, d_q, acc_q};
          end
        end
        NCA_ST_ROM: begin
          if (rom_valid_in) begin
            state_q <= NCA_ST_IDLE;
            rom_rd_q <= 1'b0;
          end
        end
        default: begin
          state_q <= NCA_ST_IDLE;
          rom_rd_q <= 1'b0;
        end
      endcase
    end
  end

  // the claimed level stays held until the word has landed
  assign stack_claim_out = (state_q == NCA_ST_ROM);

  // refused table reads leave acc, carry, b and d untouched, close any load run and raise a pulse
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      page_err_q <= 1'b0;
      stack_ovf_q <= 1'b0;
    end else begin
      page_err_q <= exec && (op == NCA_OP_TBR) && tbr_page_bad;
      stack_ovf_q <= exec && (op == NCA_OP_TBR) && !tbr_page_bad && stack_full_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      acc_q <= `NCA_ACC_RST;
    end else if (state_q == NCA_ST_ROM && rom_valid_in) begin
      acc_q <= rom_data_in[`NCA_ROM_A_MSB:`NCA_ROM_A_LSB];
    end else if (exec) begin
      case (op)
        NCA_OP_LDI: acc_q <= imm;
        NCA_OP_ADDM: acc_q <= sum_m[`NCA_NIB_W-1:0];
        NCA_OP_ADDC: acc_q <= sum_c[`NCA_NIB_W-1:0];
        NCA_OP_ADDI: acc_q <= sum_i[`NCA_NIB_W-1:0];
        NCA_OP_AND: acc_q <= acc_q & mem_rdata_in;
        NCA_OP_OR: acc_q <= acc_q | mem_rdata_in;
        NCA_OP_CPL: acc_q <= ~acc_q;
        NCA_OP_ROR: acc_q <= {carry_q, acc_q[`NCA_NIB_W-1:1]};
        default: acc_q <= acc_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // carry flag
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      carry_q <= `NCA_CARRY_RST;
    end else if (exec) begin
      case (op)
        NCA_OP_ADDC: carry_q <= sum_c[`NCA_NIB_W];
        NCA_OP_SETC: carry_q <= 1'b1;
        NCA_OP_CLRC: carry_q <= 1'b0;
        NCA_OP_ROR: carry_q <= acc_q[0];
        default: carry_q <= carry_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // b and d registers, loaded only by the table read
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      b_q <= `NCA_B_RST;
      d_q <= `NCA_D_RST;
    end else if (state_q == NCA_ST_ROM && rom_valid_in) begin
      b_q <= rom_data_in[`NCA_ROM_B_MSB:`NCA_ROM_B_LSB];
      d_q <= {1'b0, rom_data_in[`NCA_ROM_D_MSB:`NCA_ROM_D_LSB]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data memory bit writes, one cycle after the instruction
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mem_we_q <= 1'b0;
      mem_wdata_q <= '0;
    end else begin
      mem_we_q <= exec && (op == NCA_OP_BSET || op == NCA_OP_BCLR);
      if (exec && op == NCA_OP_BSET) begin
        mem_wdata_q <= mem_rdata_in | bit_mask;
      end else if (exec && op == NCA_OP_BCLR) begin
        mem_wdata_q <= mem_rdata_in & ~bit_mask;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // skip status and load run tracking
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      skip_q <= 1'b0;
    end else if (take) begin
      // a skipped slot never arms a new skip
      skip_q <= exec && skip_cond;
    end
  end

  // a run stays open across suppressed loads, so only its first one counts
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ldi_run_q <= 1'b0;
    end else if (take) begin
      ldi_run_q <= (op == NCA_OP_LDI);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign mem_we_out = mem_we_q;
  assign mem_wdata_out = mem_wdata_q;
  assign rom_rd_out = rom_rd_q;
  assign rom_addr_out = rom_addr_q;
  assign acc_out = acc_q;
  assign carry_flag_out = carry_q;
  assign b_reg_out = b_q;
  assign d_reg_out = d_q;
  assign skip_out = skip_q;
  assign page_err_out = page_err_q;
  assign stack_ovf_out = stack_ovf_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  property p_ldi_run;
    take && ldi_run_q && op == NCA_OP_LDI |=> $stable(acc_q) && !skip_q;
  endproperty
  a_ldi_run: assert property (p_ldi_run) else $error("repeated load changed acc");

  property p_tbr_split;
    state_q == NCA_ST_ROM && rom_valid_in |=> acc_q == $past(rom_data_in[3:0])
      && b_q == $past(rom_data_in[7:4]) && d_q == {1'b0, $past(rom_data_in[9:8])};
  endproperty
  a_tbr_split: assert property (p_tbr_split) else $error("table word split wrong");

  property p_tbr_addr;
    tbr_start |=> rom_rd_out && rom_addr_out == {$past(instr_in.page), $past(d_q), $past(acc_q)};
  endproperty
  a_tbr_addr: assert property (p_tbr_addr) else $error("table address wrong");

  property p_tbr_claim;
    tbr_start |=> stack_claim_out && !instr_ready_out;
  endproperty
  a_tbr_claim: assert property (p_tbr_claim) else $error("stack level not claimed");

  property p_addm;
    exec && op == NCA_OP_ADDM |=> acc_q == $past(sum_m[3:0]) && $stable(carry_q);
  endproperty
  a_addm: assert property (p_addm) else $error("add memory wrong");

  property p_addc;
    exec && op == NCA_OP_ADDC |=> {carry_q, acc_q} == $past(sum_c);
  endproperty
  a_addc: assert property (p_addc) else $error("add with carry wrong");

  property p_addi;
    exec && op == NCA_OP_ADDI |=> skip_q == !$past(sum_i[4]) && $stable(carry_q);
  endproperty
  a_addi: assert property (p_addi) else $error("add immediate skip wrong");

  property p_ror;
    exec && op == NCA_OP_ROR |=> acc_q == {$past(carry_q), $past(acc_q[3:1])}
      && carry_q == $past(acc_q[0]);
  endproperty
  a_ror: assert property (p_ror) else $error("rotate wrong");

  property p_bset;
    exec && op == NCA_OP_BSET |=> mem_we_out && mem_wdata_out[$past(bit_idx)];
  endproperty
  a_bset: assert property (p_bset) else $error("bit set wrong");

  property p_cmpi;
    exec && op == NCA_OP_CMPI |=> skip_q == ($past(acc_q) == $past(imm));
  endproperty
  a_cmpi: assert property (p_cmpi) else $error("immediate compare wrong");

  property p_skipped;
    take && skip_q |=> $stable(acc_q) && $stable(carry_q) && !mem_we_out && !skip_q;
  endproperty
  a_skipped: assert property (p_skipped) else $error("skipped slot had effect");

  property p_page;
    take && !skip_q && op == NCA_OP_TBR && tbr_page_bad |=> page_err_out && !rom_rd_out;
  endproperty
  a_page: assert property (p_page) else $error("bad page not refused");

  c_tbr: cover property (tbr_start ##[1:8] rom_valid_in ##1 instr_ready_out);
  c_ldi_run: cover property (exec && op == NCA_OP_LDI ##1 take && ldi_suppr);
  c_addi_ovf: cover property (exec && op == NCA_OP_ADDI && sum_i[4]);
  c_skip: cover property (exec && skip_cond ##1 take && skip_q);

endmodule

// ===== nca_far_model.sv
// nca_far_model.sv: pointed data memory nibble and table rom facing the alu
// assumes the bench pokes memory only in cycles where the alu writes nothing
`timescale 1ns/1ns
module nca_far_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // data memory
  input wire logic mem_we_in,
  input wire logic [3:0] mem_wdata_in,
  input wire logic poke_in,
  input wire logic [3:0] poke_data_in,
  output logic [3:0] mem_rdata_out,
  // table rom
  input wire logic rom_rd_in,
  input wire logic [12:0] rom_addr_in,
  input wire logic [1:0] dly_in,
  output logic rom_valid_out,
  output logic [9:0] rom_data_out
);
  logic [1:0] cnt_q;
  logic [9:0] word;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mem_rdata_out <= 4'h0;
    end else if (mem_we_in) begin
      mem_rdata_out <= mem_wdata_in;
    end else if (poke_in) begin
      mem_rdata_out <= poke_data_in;
    end
  end
  // answer after a chosen wait; valid never stands two cycles
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q <= 2'h0;
      rom_valid_out <= 1'b0;
    end else if (rom_rd_in && !rom_valid_out && cnt_q == dly_in) begin
      cnt_q <= 2'h0;
      rom_valid_out <= 1'b1;
    end else if (rom_rd_in && !rom_valid_out) begin
      cnt_q <= cnt_q + 2'h1;
    end else begin
      cnt_q <= 2'h0;
      rom_valid_out <= 1'b0;
    end
  end
  assign word = rom_addr_in[9:0] ^ {rom_addr_in[12:10], 7'h55};
  // outside the answer the bus shows a different pattern
  assign rom_data_out = rom_valid_out ? word : ~word;
endmodule

// ===== nca_alu_bench.sv
// nca_alu_bench.sv: random and directed instruction stream against a model
// assumes nca_alu with the small program memory and nca_far_model beside it
`timescale 1ns/1ns
module nca_alu_bench;
  import nca_pkg::*;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic valid = 1'b0;
  nca_instr_t instr = '0;
  logic sfull = 1'b0;
  logic poke = 1'b0;
  logic [3:0] poke_d = 4'h0;
  logic [1:0] dly = 2'h0;
  logic ready, we, rd, rv, claim, skip, cy, perr, ovf;
  logic [3:0] rdata, wdata, acc, b;
  logic [2:0] d;
  logic [12:0] addr;
  logic [9:0] rdat;
  int seed = 89113;
  int error_cnt = 0;
  int check_count = 0;
  logic [3:0] e_acc = 4'h0, e_b = 4'h0, e_mem = 4'h0, pend_d = 4'h0;
  logic [2:0] e_d = 3'h0;
  logic e_c = 1'b0, e_skip = 1'b0, e_run = 1'b0, pend_v = 1'b0;
  always #50 clk_in = ~clk_in;
  nca_alu #(.PAGE_MAX(47)) uut (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .instr_valid_in(valid), .instr_in(instr), .instr_ready_out(ready),
    .mem_rdata_in(rdata), .mem_we_out(we), .mem_wdata_out(wdata),
    .rom_rd_out(rd), .rom_addr_out(addr), .rom_valid_in(rv), .rom_data_in(rdat),
    .stack_full_in(sfull), .stack_claim_out(claim), .acc_out(acc),
    .carry_flag_out(cy), .b_reg_out(b), .d_reg_out(d), .skip_out(skip),
    .page_err_out(perr), .stack_ovf_out(ovf));
  nca_far_model far (.clk_in(clk_in), .arst_n_in(arst_n_in), .mem_we_in(we),
    .mem_wdata_in(wdata), .poke_in(poke), .poke_data_in(poke_d), .mem_rdata_out(rdata),
    .rom_rd_in(rd), .rom_addr_in(addr), .dly_in(dly), .rom_valid_out(rv),
    .rom_data_out(rdat));
  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [12:0] seen, input logic [12:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [9:0] rom_f(input logic [12:0] a);
    return a[9:0] ^ {a[12:10], 7'h55};
  endfunction
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task step;
    @(posedge clk_in);
    #1;
    if (pend_v) e_mem = pend_d;
    pend_v = 1'b0;
  endtask
  task issue(input nca_op_t op, input logic [3:0] imm, input logic [5:0] page);
    logic [3:0] m;
    logic [4:0] s;
    logic sk;
    logic [9:0] w;
    int n;
    logic pe;
    logic po;
    instr = {op, imm, page};
    valid = 1'b1;
    m = e_mem;
    sk = e_skip;
    pe = (op == NCA_OP_TBR) && !sk && (page > 6'd47);
    po = (op == NCA_OP_TBR) && !sk && (page <= 6'd47) && sfull;
    step();
    e_skip = 1'b0;
    if (!sk) begin
      case (op)
        NCA_OP_LDI: if (!e_run) e_acc = imm;
        NCA_OP_ADDM: e_acc = e_acc + m;
        NCA_OP_ADDC: {e_c, e_acc} = e_acc + m + e_c;
        NCA_OP_ADDI: begin
          s = e_acc + imm;
          e_acc = s[3:0];
          e_skip = !s[4];
        end
        NCA_OP_AND: e_acc = e_acc & m;
        NCA_OP_OR: e_acc = e_acc | m;
        NCA_OP_SETC: e_c = 1'b1;
        NCA_OP_CLRC: e_c = 1'b0;
        NCA_OP_TSTC: e_skip = !e_c;
        NCA_OP_CPL: e_acc = ~e_acc;
        NCA_OP_ROR: {e_acc, e_c} = {e_c, e_acc};
        NCA_OP_BSET: {pend_v, pend_d} = {1'b1, m | (4'h1 << imm[1:0])};
        NCA_OP_BCLR: {pend_v, pend_d} = {1'b1, m & ~(4'h1 << imm[1:0])};
        NCA_OP_BTST: e_skip = !m[imm[1:0]];
        NCA_OP_CMPM: e_skip = (e_acc == m);
        NCA_OP_CMPI: e_skip = (e_acc == imm);
        NCA_OP_TBR: begin
          if (page > 6'd47) begin
            check(perr, 1'b1);
          end else if (sfull) begin
            check(ovf, 1'b1);
          end else begin
            check({claim, rd, ready}, 3'b110);
            check(addr, {page, e_d, e_acc});
            n = 0;
            while (!ready && n < 20) begin
              step();
              n++;
            end
            w = rom_f({page, e_d, e_acc});
            {e_d, e_b, e_acc} = {1'b0, w};
          end
        end
        default: ;
      endcase
    end
    e_run = (op == NCA_OP_LDI);
    check(acc, e_acc);
    check(cy, e_c);
    check(skip, e_skip);
    check({b, d}, {e_b, e_d});
    check(we, pend_v);
    if (pend_v) check(wdata, pend_d);
    check(rdata, e_mem);
    check({perr, ovf, ready, claim, rd}, {pe, po, 3'b100});
  endtask
  task poke_mem(input logic [3:0] v);
    valid = 1'b0;
    step();
    poke = 1'b1;
    poke_d = v;
    step();
    poke = 1'b0;
    e_mem = v;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(30000 * 100);
    error_cnt++;
    give_verdict();
  end
  initial begin
    nca_op_t op;
    repeat (20) @(posedge clk_in);
    #1;
    arst_n_in = 1'b1;
    check(ready, 1'b1);
    check({acc, cy, skip, b, d}, 13'h0000);
    poke_mem(4'h6);
    // load run, overflow edge of add immediate, skipped compare
    issue(NCA_OP_LDI, 4'h5, 6'h00);
    issue(NCA_OP_LDI, 4'h9, 6'h00);
    issue(NCA_OP_LDI, 4'h3, 6'h00);
    issue(NCA_OP_CPL, 4'h0, 6'h00);
    issue(NCA_OP_ADDI, 4'h6, 6'h00);
    issue(NCA_OP_ADDI, 4'h2, 6'h00);
    issue(NCA_OP_CMPI, 4'h2, 6'h00);
    issue(NCA_OP_SETC, 4'h0, 6'h00);
    issue(NCA_OP_ROR, 4'h0, 6'h00);
    issue(NCA_OP_TBR, 4'h0, 6'd47);
    issue(NCA_OP_TBR, 4'h0, 6'd48);
    $display("directed cases done");
    for (int i = 0; i < 1500; i++) begin
      if (i % 8 == 0) poke_mem(4'($random(seed)));
      op = nca_op_t'(5'($unsigned($random(seed)) % 18));
      if (e_skip && op == NCA_OP_LDI) op = NCA_OP_NOP;
      dly = 2'($random(seed));
      sfull = (($random(seed) & 7) == 0);
      issue(op, 4'($random(seed)), 6'($random(seed)));
      sfull = 1'b0;
    end
    valid = 1'b0;
    $display("random stream done");
    give_verdict();
  end
endmodule
